/* core/snr_receiver.sv */
// single-wire sensor link receiver with ahb-lite register slave
// Functional notes
// - receive mode when receive select bit set
// - sync accepted when interval within limits
// - capture sync time, derive tick from it
// - check nibble widths, store nibbles in data
// - interrupt event on every complete message
// - nibble count field sets data nibbles
// - crc enable selects hardware crc check
// - pause bit expects pause pulse per frame
// - enable bit activates module after setup
// - tick equals prescaled clock times setting plus one
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "snr_map.svh"
module snr_receiver
  import snr_pkg::*;
#(
  parameter int unsigned PRESCALE = 1
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // link and interrupt
  input  wire logic        i_sent,
  output logic             o_irq
);

  // six data nibbles plus status and crc fit one 32-bit word
  function automatic logic [2:0] nib_count(input logic [2:0] f);
    if (f == 3'h0) begin
      return 3'h1;
    end else if (f == 3'h7) begin
      return 3'h6;
    end
    return f;
  endfunction

  function automatic logic [3:0] crc4(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    logic       fb;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      fb = r[3] ^ n[i];
      r  = {r[2:0], 1'b0} ^ (fb ? `SNR_CRC_POLY : 4'h0);
    end
    return r;
  endfunction

  // bus state
  logic        wr_q,    wr_d;
  logic [7:0]  addr_q,  addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] ctrl_q,  ctrl_d;
  logic [15:0] smax_q,  smax_d;
  logic [15:0] smin_q,  smin_d;
  logic [15:0] tick_q,  tick_d;
  logic [15:0] frame_q, frame_d;
  logic [2:0]  ien_q,   ien_d;
  logic [2:0]  stat_q,  stat_d;
  logic [2:0]  iclr;
  // link state
  logic        sent_q;
  logic [7:0]  pre_q,   pre_d;
  logic [15:0] ivl_q,   ivl_d;
  logic [15:0] tkc_q,   tkc_d;
  logic [15:0] ftk_q,   ftk_d;
  logic [15:0] sync_q,  sync_d;
  logic [31:0] sh_q,    sh_d;
  logic [31:0] dat_q,   dat_d;
  logic [3:0]  crc_q,   crc_d;
  logic [2:0]  idx_q,   idx_d;
  snr_state_t  st_q,    st_d;
  // decode helpers
  logic        ap_valid;
  logic        pre_en;
  logic        tick_stb;
  logic        fall;
  logic        run;
  logic        in_sync;
  logic        nib_ok;
  logic        pause_ok;
  logic        do_start;
  logic [23:0] iv_x;
  logic [15:1] ge;
  logic [3:0]  nib_val;
  logic [2:0]  nlast;
  logic [2:0]  ev;

  assign ap_valid    = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_q;
  assign o_irq       = |(stat_q & ien_q);

  // register file
  always_comb begin
    wr_d    = ap_valid & i_hwrite;
    addr_d  = ap_valid ? i_haddr[7:0] : addr_q;
    ctrl_d  = ctrl_q;
    smax_d  = smax_q;
    smin_d  = smin_q;
    tick_d  = tick_q;
    frame_d = frame_q;
    ien_d   = ien_q;
    iclr    = 3'h0;
    if (wr_q) begin
      case (addr_q)
        `SNR_OFS_CTRL:  ctrl_d  = i_hwdata[15:0];
        `SNR_OFS_SMAX:  smax_d  = i_hwdata[15:0];
        `SNR_OFS_SMIN:  smin_d  = i_hwdata[15:0];
        `SNR_OFS_TICK:  tick_d  = i_hwdata[15:0];
        `SNR_OFS_FRAME: frame_d = i_hwdata[15:0];
        `SNR_OFS_ICLR:  iclr    = i_hwdata[2:0];
        `SNR_OFS_IEN:   ien_d   = i_hwdata[2:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    stat_d  = (stat_q & ~iclr) | ev;
    rdata_d = 32'h0000_0000;
    if (ap_valid && !i_hwrite) begin
      case (i_haddr[7:0])
        `SNR_OFS_CTRL:  rdata_d = {16'h0000, ctrl_q};
        `SNR_OFS_SMAX:  rdata_d = {16'h0000, smax_q};
        `SNR_OFS_SMIN:  rdata_d = {16'h0000, smin_q};
        `SNR_OFS_TICK:  rdata_d = {16'h0000, tick_q};
        `SNR_OFS_FRAME: rdata_d = {16'h0000, frame_q};
        `SNR_OFS_SYNC:  rdata_d = {16'(sync_q / 16'd56), sync_q};
        `SNR_OFS_DATH:  rdata_d = {16'h0000, dat_q[31:16]};
        `SNR_OFS_DATL:  rdata_d = {16'h0000, dat_q[15:0]};
        `SNR_OFS_STAT:  rdata_d = {29'h0000_0000, stat_q};
        `SNR_OFS_IEN:   rdata_d = {29'h0000_0000, ien_q};
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      rdata_q <= 32'h0000_0000;
      ctrl_q  <= `SNR_CTRL_RST;
      smax_q  <= `SNR_LIM_RST;
      smin_q  <= `SNR_LIM_RST;
      tick_q  <= `SNR_LIM_RST;
      frame_q <= `SNR_LIM_RST;
      ien_q   <= `SNR_STAT_RST;
      stat_q  <= `SNR_STAT_RST;
    end else begin
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
      smax_q  <= smax_d;
      smin_q  <= smin_d;
      tick_q  <= tick_d;
      frame_q <= frame_d;
      ien_q   <= ien_d;
      stat_q  <= stat_d;
    end
  end

  // interval decode: compare interval*112 with sync*(2w-1), i.e. half-tick bounds
  assign iv_x = 24'(ivl_q * (2 * `SNR_SYNC_TICKS));
  for (genvar k = 1; k < 16; k++) begin : g_thr
    assign ge[k] = iv_x >= 24'(sync_q * (2 * `SNR_NIB_MIN_TK - 1 + 2 * k));
  end
  assign pause_ok = iv_x >= 24'(sync_q * (2 * `SNR_NIB_MIN_TK - 1));
  assign nib_ok   = pause_ok && (iv_x < 24'(sync_q * (2 * `SNR_NIB_MAX_TK + 1)));
  assign in_sync  = (ivl_q >= smin_q) && (ivl_q <= smax_q);
  assign pre_en   = pre_q == 8'(PRESCALE - 1);
  assign tick_stb = pre_en && (tkc_q == tick_q);
  assign fall     = sent_q & ~i_sent;
  assign run      = ctrl_q[`SNR_BIT_EN] & ctrl_q[`SNR_BIT_RCV];
  assign nlast    = nib_count(ctrl_q[`SNR_NIB_HI:`SNR_NIB_LO]) + 3'h1;

  // receive engine
  always_comb begin
    nib_val = 4'h0;
    for (int k = 1; k < 16; k++) begin
      nib_val = nib_val + 4'(ge[k]);
    end
    pre_d    = pre_en ? 8'h00 : 8'(pre_q + 8'h01);
    ivl_d    = ivl_q;
    if (fall) begin
      ivl_d = 16'h0000;
    end else if (pre_en && ivl_q != 16'hFFFF) begin
      ivl_d = 16'(ivl_q + 16'h0001);
    end
    tkc_d    = pre_en ? (tick_stb ? 16'h0000 : 16'(tkc_q + 16'h0001)) : tkc_q;
    ftk_d    = (tick_stb && ftk_q != 16'hFFFF) ? 16'(ftk_q + 16'h0001) : ftk_q;
    st_d     = st_q;
    sync_d   = sync_q;
    sh_d     = sh_q;
    dat_d    = dat_q;
    crc_d    = crc_q;
    idx_d    = idx_q;
    ev       = 3'h0;
    do_start = 1'b0;
    if (!run) begin
      st_d = st_off;
    end else begin
      case (st_q)
        st_off: begin
          st_d = st_hunt;
        end
        st_hunt: begin
          do_start = fall && in_sync;
        end
        st_data: begin
          if (fall) begin
            if (nib_ok) begin
              sh_d  = {sh_q[27:0], nib_val};
              idx_d = 3'(idx_q + 3'h1);
              if (idx_q != 3'h0 && idx_q != nlast) begin
                crc_d = crc4(crc_q, nib_val);
              end
              if (idx_q == nlast) begin
                dat_d = {sh_q[27:0], nib_val};
                ev[`SNR_ST_DONE] = 1'b1;
                if (ctrl_q[`SNR_BIT_CRC] && crc4(crc_q, 4'h0) != nib_val) begin
                  ev[`SNR_ST_CRCERR] = 1'b1;
                end
                st_d = ctrl_q[`SNR_BIT_PPP] ? st_pause : st_hunt;
              end
            end else if (in_sync) begin
              ev[`SNR_ST_FRMERR] = 1'b1;
              do_start = 1'b1;
            end else begin
              ev[`SNR_ST_FRMERR] = 1'b1;
              st_d = st_hunt;
            end
          end else if (frame_q != 16'h0000 && ftk_q >= frame_q) begin
            // a stuck line ends here rather than waiting for an edge
            ev[`SNR_ST_FRMERR] = 1'b1;
            st_d = st_hunt;
          end
        end
        st_pause: begin
          if (fall) begin
            if (in_sync) begin
              do_start = 1'b1;
            end else begin
              ev[`SNR_ST_FRMERR] = !pause_ok;
              st_d = st_hunt;
            end
          end
        end
        default: begin
          st_d = st_hunt;
        end
      endcase
    end
    if (do_start) begin
      sync_d = ivl_q;
      st_d   = st_data;
      idx_d  = 3'h0;
      sh_d   = 32'h0000_0000;
      crc_d  = `SNR_CRC_SEED;
      ftk_d  = 16'h0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sent_q <= 1'b1;
      pre_q  <= 8'h00;
      ivl_q  <= 16'h0000;
      tkc_q  <= 16'h0000;
      ftk_q  <= 16'h0000;
      sync_q <= 16'h0000;
      sh_q   <= 32'h0000_0000;
      dat_q  <= 32'h0000_0000;
      crc_q  <= `SNR_CRC_SEED;
      idx_q  <= 3'h0;
      st_q   <= st_off;
    end else begin
      sent_q <= i_sent;
      pre_q  <= pre_d;
      ivl_q  <= ivl_d;
      tkc_q  <= tkc_d;
      ftk_q  <= ftk_d;
      sync_q <= sync_d;
      sh_q   <= sh_d;
      dat_q  <= dat_d;
      crc_q  <= crc_d;
      idx_q  <= idx_d;
      st_q   <= st_d;
    end
  end

endmodule // snr_receiver
`default_nettype wire

/* core/snr_map.svh */
// register offsets, field positions, reset values and timing figures of the receiver
`ifndef SNR_MAP_SVH
`define SNR_MAP_SVH
`define SNR_OFS_CTRL    8'h00
`define SNR_OFS_SMAX    8'h04
`define SNR_OFS_SMIN    8'h08
`define SNR_OFS_TICK    8'h0C
`define SNR_OFS_FRAME   8'h10
`define SNR_OFS_SYNC    8'h14
`define SNR_OFS_DATH    8'h18
`define SNR_OFS_DATL    8'h1C
`define SNR_OFS_STAT    8'h20
`define SNR_OFS_ICLR    8'h24
`define SNR_OFS_IEN     8'h28
`define SNR_BIT_EN      15
`define SNR_BIT_RCV     11
`define SNR_BIT_CRC     8
`define SNR_BIT_PPP     7
`define SNR_NIB_HI      2
`define SNR_NIB_LO      0
`define SNR_ST_DONE     0
`define SNR_ST_CRCERR   1
`define SNR_ST_FRMERR   2
`define SNR_CTRL_RST    16'h0000
`define SNR_LIM_RST     16'h0000
`define SNR_STAT_RST    3'h0
`define SNR_SYNC_TICKS  56
`define SNR_NIB_MIN_TK  12
`define SNR_NIB_MAX_TK  27
`define SNR_CRC_SEED    4'h5
`define SNR_CRC_POLY    4'hD
`endif

/* core/snr_pkg.sv */
// types shared by the receiver
package snr_pkg;
  typedef enum logic [3:0] {
    st_off   = 4'b0001,
    st_hunt  = 4'b0010,
    st_data  = 4'b0100,
    st_pause = 4'b1000
  } snr_state_t;
endpackage

/* bench/snr_receiver_monitor.sv */
// assertion checker on the receiver ports
`timescale 1ns/1ps
`default_nettype none
module snr_receiver_monitor (
  // watched ports
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_sent,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_irq
);
  logic       rd_q, wd_q, sent_q;
  logic [2:0] fall_q;
  logic [7:0] ra_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // no reset needed: reset spans enough edges to flush these
  always_ff @(posedge i_clk) begin
    rd_q <= i_hsel & i_htrans[1] & o_hreadyout & !i_hwrite;
    wd_q <= i_hsel & i_htrans[1] & o_hreadyout & i_hwrite;
    sent_q <= i_sent;
    fall_q <= {fall_q[1:0], sent_q & !i_sent};
    ra_q <= i_haddr[7:0];
  end
  ready_high_a: assert property (o_hreadyout) else $error("wait state inserted");
  resp_okay_a: assert property (!o_hresp) else $error("error response");
  rdata_idle_a: assert property (!rd_q |-> o_hrdata == 32'h0000_0000)
    else $error("read data outside read");
  unmapped_zero_a: assert property (rd_q && ra_q > 8'h28 |-> o_hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_q && ra_q != 8'h14 |-> o_hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  status_width_a: assert property (rd_q && ra_q == 8'h20 |-> o_hrdata[31:3] == 29'h0)
    else $error("status wider than three bits");
  irq_rise_a: assert property ($rose(o_irq) |-> (|fall_q) || $past(wd_q))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(wd_q))
    else $error("irq fell without write");
endmodule // snr_receiver_monitor
`default_nettype wire

/* bench/snr_sensor_model.sv */
// single-wire sensor transmitter model
`timescale 1ns/1ps
`default_nettype none
module snr_sensor_model #(
  parameter int TK = 4
) (
  // clock and line
  input wire logic i_clk,
  output var logic o_sent
);
  // pulled-up line idles high between frames
  initial o_sent = 1'b1;
  // one fall-to-fall interval of t ticks, low for the first four
  // a short pause pulse goes low for one tick only, so the line rises before the next fall
  task automatic pulse(input int t);
    int lo;
    lo = (t > 4) ? 4 * TK : TK;
    o_sent <= 1'b0;
    repeat (lo) @(posedge i_clk);
    o_sent <= 1'b1;
    repeat (t * TK - lo) @(posedge i_clk);
  endtask
endmodule // snr_sensor_model
`default_nettype wire

/* bench/snr_receiver_bench.sv */
// self-checking bench for the receiver
`timescale 1ns/1ps
`default_nettype none
module snr_receiver_bench;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
  logic [1:0]  i_htrans = 2'b00;
  logic [2:0]  i_hsize = 3'b000;
  logic [31:0] i_haddr = 32'h0000_0000, i_hwdata = 32'h0000_0000, o_hrdata, rd, e;
  logic        o_hreadyout, o_hresp, o_irq;
  wire logic   i_sent;
  int          fail_count = 0, checks_done = 0;
  always #20 i_clk = ~i_clk;
  snr_sensor_model #(.TK(4)) sen (.i_clk(i_clk), .o_sent(i_sent));
  snr_receiver uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_hrdata(o_hrdata), .i_sent(i_sent), .o_irq(o_irq));
  task automatic chk(input string n, input logic [31:0] s, x);
    checks_done++;
    if (s !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hold;
    for (int n = 0; n < 9 && (n == 0 || o_hreadyout !== 1'b1); n++) @(posedge i_clk);
    if (o_hreadyout !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask
  // an empty name skips the read compare
  task automatic bus(input string nm, input logic w, input logic [7:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_haddr <= {24'h00_0000, a};
    i_htrans <= 2'b10;
    i_hsize <= 3'b010;
    i_hwrite <= w;
    hold();
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= d;
    hold();
    rd = o_hrdata;
    if (!w && nm != "") chk(nm, rd, d);
  endtask
  task automatic st(input logic [31:0] x);
    bus("status", 1'b0, 8'h20, x);
    bus("", 1'b1, 8'h24, 32'h0000_0007);
  endtask
  // status nibble 9, n data nibbles, crc nibble c; e gets the expected data word
  task automatic frame(input int n, sy, input logic [3:0] c);
    logic [3:0] v;
    e = 32'h0000_0009;
    sen.pulse(sy);
    sen.pulse(21);
    for (int i = 0; i < n; i++) begin
      v = 4'((i * 5 + n) & 15);
      e = {e[27:0], v};
      sen.pulse(12 + v);
    end
    e = {e[27:0], c};
    sen.pulse(12 + c);
    sen.pulse(4);
  endtask
  initial begin
    int n;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus("ctrl", 1'b0, 8'h00, 32'h0000_0000);
    bus("unmapped", 1'b0, 8'h40, 32'h0000_0000);
    bus("", 1'b1, 8'h04, 32'h0000_010C);
    bus("", 1'b1, 8'h08, 32'h0000_00B3);
    bus("", 1'b1, 8'h0C, 32'h0000_0003);
    bus("", 1'b1, 8'h10, 32'h0000_0374);
    bus("", 1'b1, 8'h28, 32'h0000_0001);
    bus("max limit", 1'b0, 8'h04, 32'h0000_010C);
    bus("", 1'b1, 8'h00, 32'h0000_8006);
    frame(6, 56, 4'h0);
    st(32'h0000_0000);
    for (int f = 0; f < 8; f++) begin
      bus("", 1'b1, 8'h00, 32'h0000_8800 | f);
      frame(f == 0 ? 1 : f == 7 ? 6 : f, 56, 4'hA);
      chk("irq", o_irq, 1'b1);
      bus("data high", 1'b0, 8'h18, e >> 16);
      bus("data low", 1'b0, 8'h1C, e & 32'h0000_FFFF);
      st(32'h0000_0001);
    end
    bus("", 1'b0, 8'h14, 32'h0000_0000);
    chk("sync", rd[15:0] > 222 && rd[15:0] < 226, 1'b1);
    bus("", 1'b1, 8'h28, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      bus("", 1'b1, 8'h00, 32'h0000_8801 | k << 8);
      for (int c = 0; c < 16; c++) begin
        frame(1, 56, 4'(c));
        chk("masked irq", o_irq, 1'b0);
        bus("", 1'b0, 8'h20, 32'h0000_0000);
        n += rd[1];
        bus("", 1'b1, 8'h24, 32'h0000_0007);
      end
      chk("crc errors", n, 15 * k);
    end
    bus("", 1'b1, 8'h00, 32'h0000_8883);
    frame(3, 56, 4'h0);
    sen.pulse(4);
    st(32'h0000_0005);
    frame(3, 44, 4'h0);
    frame(3, 70, 4'h0);
    st(32'h0000_0000);
    sen.pulse(56);
    sen.pulse(30);
    sen.pulse(4);
    st(32'h0000_0004);
    // line stuck high after the status nibble: frame length limit ends the message
    sen.pulse(56);
    sen.pulse(21);
    repeat (3400) @(posedge i_clk);
    st(32'h0000_0000);
    repeat (100) @(posedge i_clk);
    st(32'h0000_0004);
    give_verdict();
  end
endmodule // snr_receiver_bench
bind snr_receiver snr_receiver_monitor mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_sent(i_sent),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_irq(o_irq));
`default_nettype wire
